/* cafm_map.svh */
// Constants for the accumulator-to-file copy decoder.
// Assumes a single core clock; included by the package and the design module.
//
// Functional notes
// RULE1 - Opcode 00_0000_1 plus seven-bit file address
// RULE2 - Copy accumulator unchanged; accumulator, flags untouched
// RULE3 - One word, one cycle of four phases
// RULE4 - Decode, read, process, write in phases one-four
`ifndef CAFM_MAP_SVH
`define CAFM_MAP_SVH
`define CAFM_INSTR_W      14
`define CAFM_ADDR_W       7
`define CAFM_DATA_W       8
`define CAFM_OPC_HI       13
`define CAFM_OPC_LO       7
`define CAFM_OPC_VALUE    7'h01
`define CAFM_ACC_RESET    8'h00
`endif

/* cafm_pkg.sv */
// Types for the accumulator-to-file copy decoder.
// Assumes cafm_map.svh is on the include path.
`include "cafm_map.svh"
package cafm_pkg;
    // Phase of the instruction cycle
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cafm_phase_type;

    // File register write request
    typedef struct packed {
        logic                         we;
        logic [`CAFM_ADDR_W-1:0]      addr;
        logic [`CAFM_DATA_W-1:0]      data;
    } cafm_wr_type;
endpackage : cafm_pkg

/* cafm_copy_acc_to_file.sv */
// Executes the copy_acc_to_file instruction over one four-phase cycle.
// Assumes instr_i is held stable by the fetch logic for a full cycle and
// that instr_valid_i is sampled in phase Q1 only.
`timescale 1ns/10ps
`include "cafm_map.svh"
module cafm_copy_acc_to_file
    import cafm_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    resetn_i,
    // Instruction stream
    input  wire logic                    instr_valid_i,
    input  wire logic [`CAFM_INSTR_W-1:0] instr_i,
    // Accumulator load from other instructions
    input  wire logic                    acc_we_i,
    input  wire logic [`CAFM_DATA_W-1:0] acc_data_i,
    // Status
    output logic      [1:0]              phase_o,
    output logic                         hit_o,
    output logic [`CAFM_DATA_W-1:0]      acc_o,
    // File register write port
    output cafm_wr_type                  file_wr_o
);

    // Limitation: the word must be held through Q1; a change later in the
    // cycle only reaches the next decode, never the write already in flight.

    // Phase sequencer: current phase and the phase after the next edge
    cafm_phase_type               phase_reg;
    cafm_phase_type               phase_next;

    // Decode result, taken in Q1 and held until the next Q1
    logic                         hit_reg;
    logic                         hit_next;

    // File address captured from the word in Q1
    logic [`CAFM_ADDR_W-1:0]      addr_reg;
    logic [`CAFM_ADDR_W-1:0]      addr_next;

    // Working accumulator, loaded only by other instructions
    logic [`CAFM_DATA_W-1:0]      acc_reg;
    logic [`CAFM_DATA_W-1:0]      acc_next;

    // Operand read in Q2; a copy, so a later load cannot disturb it
    logic [`CAFM_DATA_W-1:0]      data_reg;
    logic [`CAFM_DATA_W-1:0]      data_next;

    // Write request fields, each in its own flip-flop
    logic                         we_reg;
    logic                         we_next;
    logic [`CAFM_ADDR_W-1:0]      wr_addr_reg;
    logic [`CAFM_ADDR_W-1:0]      wr_addr_next;
    logic [`CAFM_DATA_W-1:0]      wr_data_reg;
    logic [`CAFM_DATA_W-1:0]      wr_data_next;
    cafm_wr_type                  wr_bus;

    // Named decode wires
    logic                         in_q1;
    logic                         in_q2;
    logic                         in_q3;
    logic                         in_q4;
    logic [`CAFM_OPC_HI-`CAFM_OPC_LO:0] opc_field;
    logic                         opc_match;
    logic [`CAFM_ADDR_W-1:0]      addr_field;
    logic                         decode_hit;

    // One wire per phase keeps the per-register selects readable
    assign in_q1 = (phase_reg == PH_Q1);
    assign in_q2 = (phase_reg == PH_Q2);
    assign in_q3 = (phase_reg == PH_Q3);
    assign in_q4 = (phase_reg == PH_Q4);

    // Opcode match on the upper seven bits; the low seven name the file
    assign opc_field  = instr_i[`CAFM_OPC_HI:`CAFM_OPC_LO]; // RULE1
    assign opc_match  = (opc_field == `CAFM_OPC_VALUE); // RULE1
    assign addr_field = instr_i[`CAFM_ADDR_W-1:0]; // RULE1

    // Only a valid word seen in Q1 starts a copy; later phases ignore the bus
    assign decode_hit = instr_valid_i && opc_match && in_q1; // RULE4

    // Q1: decode and capture the address
    assign hit_next  = in_q1 ? decode_hit : hit_reg; // RULE4
    assign addr_next = in_q1 ? addr_field : addr_reg;

    // Q2: read the accumulator as it stands before this edge
    assign data_next = in_q2 ? acc_reg : data_reg; // RULE4

    // Q3: pass the operand through unchanged to the write data
    assign wr_data_next = in_q3 ? data_reg : wr_data_reg; // RULE2

    // Q4: raise the strobe for exactly one clock and present the address
    assign we_next      = in_q4 && hit_reg; // RULE4
    assign wr_addr_next = in_q4 ? addr_reg : wr_addr_reg;

    // The copy never writes back the accumulator; only outside loads do
    assign acc_next = acc_we_i ? acc_data_i : acc_reg; // RULE2

    // Four phases wrap every cycle, one instruction per wrap
    always_comb
    begin
        case (phase_reg)
            PH_Q1:   phase_next = PH_Q2;
            PH_Q2:   phase_next = PH_Q3;
            PH_Q3:   phase_next = PH_Q4;
            default: phase_next = PH_Q1;
        endcase
    end // RULE3

    // Register bank: one short process per flip-flop group. Every reset
    // value is a constant, so no register depends on another during reset
    // and the first edge after release always ends a clean Q1.

    // Phase register; reset parks the sequencer in Q1
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            phase_reg <= PH_Q1;
        end
        else
        begin
            phase_reg <= phase_next; // RULE3
        end
    end

    // Decode flag, refreshed only in Q1
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hit_reg <= 1'b0;
        end
        else
        begin
            hit_reg <= hit_next; // RULE4
        end
    end

    // File address from the decoded word
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            addr_reg <= '0;
        end
        else
        begin
            addr_reg <= addr_next; // RULE1
        end
    end

    // Accumulator; this instruction only reads it
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            acc_reg <= `CAFM_ACC_RESET;
        end
        else
        begin
            acc_reg <= acc_next; // RULE2
        end
    end

    // Operand latched in Q2
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            data_reg <= '0;
        end
        else
        begin
            data_reg <= data_next; // RULE4
        end
    end

    // Write strobe, high for the one clock that follows Q4
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            we_reg <= 1'b0;
        end
        else
        begin
            we_reg <= we_next; // RULE4
        end
    end

    // Write address; holds until the next Q4
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_addr_reg <= '0;
        end
        else
        begin
            wr_addr_reg <= wr_addr_next; // RULE4
        end
    end

    // Write data; set in Q3 so it is settled before the strobe rises
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_data_reg <= '0;
        end
        else
        begin
            wr_data_reg <= wr_data_next; // RULE2
        end
    end

    // Outputs come straight from flip-flops, so they settle right after
    // the edge; the write fields are gathered into one struct for the port
    assign phase_o   = phase_reg; // RULE3
    assign hit_o     = hit_reg;
    assign acc_o     = acc_reg;
    assign wr_bus    = '{we: we_reg, addr: wr_addr_reg, data: wr_data_reg};
    assign file_wr_o = wr_bus;
endmodule : cafm_copy_acc_to_file

/* cafm_copy_acc_to_file_chk.sv */
// Port checker for the copy decoder; assumes one clock and the bind below.
`timescale 1ns/10ps
module cafm_chk import cafm_pkg::*; (
    input wire logic clk_sys_i, resetn_i, instr_valid_i, acc_we_i,
    input wire logic [13:0] instr_i,
    input wire logic [1:0] phase_o,
    input wire logic [7:0] acc_o,
    input wire cafm_wr_type file_wr_o);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!resetn_i);
sequence s_take; phase_o==0 && instr_valid_i && instr_i[13:7]==7'h01; endsequence
property p_hit; s_take |-> ##4 file_wr_o.we && file_wr_o.addr==$past(instr_i[6:0],4); endproperty
a_hit: assert property (p_hit) else $error("write missing");
property p_dat; $rose(file_wr_o.we) |-> file_wr_o.data==$past(acc_o,3); endproperty
a_dat: assert property (p_dat) else $error("bad data");
property p_one; file_wr_o.we |=> !file_wr_o.we; endproperty
a_one: assert property (p_one) else $error("long write");
property p_q4; file_wr_o.we |-> phase_o==0 && $past(phase_o)==3; endproperty
a_q4: assert property (p_q4) else $error("write off phase");
sequence s_skip; phase_o==0 && !(instr_valid_i && instr_i[13:7]==7'h01); endsequence
property p_none; s_skip |-> ##4 !file_wr_o.we; endproperty
a_none: assert property (p_none) else $error("write without copy");
property p_acc; !acc_we_i |=> acc_o==$past(acc_o); endproperty
a_acc: assert property (p_acc) else $error("accumulator changed");
endmodule : cafm_chk
bind cafm_copy_acc_to_file cafm_chk i_chk (.*);

/* cafm_copy_acc_to_file_bench.sv */
// Random words against a queue model; assumes the checker is compiled too.
`timescale 1ns/10ps
module cafm_copy_acc_to_file_bench;
import cafm_pkg::*;
logic clk_sys_i=0, resetn_i=0, instr_valid_i=0, acc_we_i=0, hit_o, pend=0;
logic [13:0] instr_i='0;
logic [7:0] acc_data_i='0, acc_m='0, acc_o;
logic [1:0] phase_o, ph_m='0;
logic [31:0] r=32'd87758;
logic [14:0] q[$];
cafm_wr_type file_wr_o;
int err_total=0, samples_checked=0, cyc=0;
always #2 clk_sys_i=~clk_sys_i;
cafm_copy_acc_to_file i_dut (.clk_sys_i, .resetn_i, .instr_valid_i, .instr_i,
    .acc_we_i, .acc_data_i, .phase_o, .hit_o, .acc_o, .file_wr_o);
function logic [31:0] xs(logic [31:0] v); v^=v<<13; v^=v>>17; return v^v<<5; endfunction : xs
task chk(string n, logic [14:0] s, e);
    samples_checked++;
    if (s!==e) begin err_total++; $display("Error %s exp %h seen %h", n, e, s); end
endtask : chk
task complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total==0 && samples_checked>0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask : complete_run
// Model reads pre-edge values; words change only entering Q1
always @(posedge clk_sys_i) if (resetn_i) begin
    cyc++;
    chk("acc", acc_o, acc_m);
    chk("phase", phase_o, ph_m);
    chk("hit", hit_o, pend);
    chk("we", file_wr_o.we, ph_m==0 && q.size()!=0);
    if (ph_m==0 && q.size()!=0) chk("wr", file_wr_o[14:0], q.pop_front());
    if (ph_m==1 && pend) q.push_back({instr_i[6:0], acc_m});
    if (ph_m==0) pend=instr_valid_i && instr_i[13:7]==7'h01;
    if (acc_we_i) acc_m=acc_data_i;
    ph_m++;
    r=xs(r);
    if (ph_m==0) begin instr_valid_i<=r[0]; instr_i<={r[1]?7'h01:r[8:2], r[15:9]}; end
    acc_we_i<=r[16];
    acc_data_i<=r[24:17];
    if (cyc>3000) begin err_total++; complete_run; end
end
initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i<=1;
    repeat (400) @(posedge clk_sys_i);
    complete_run;
end
endmodule : cafm_copy_acc_to_file_bench
